// *** hdl/bbt_defines.svh ***
/*
 * constants for the bidirectional bus transceiver: widths, boundary cell
 * layout, reset values and test opcodes.
 * assumes inclusion by bare name from the design file, the bus model and the bench.
 */
`ifndef BBT_DEFINES_SVH
`define BBT_DEFINES_SVH
// ==================================================
// data path
`define BBT_W 20
// ==================================================
// boundary cells: [19:0] a pins, [39:20] b pins, then controls
`define BBT_BS_W 48
`define BBT_BS_B_LO 20
`define BBT_BS_CTL 40
`define BBT_BS_OE_A 46
`define BBT_BS_OE_B 47
`define BBT_BS_RESET 48'hC000_0000_0000
// ==================================================
// instruction register and opcodes
`define BBT_IR_W 8
`define BBT_IR_RESET 8'h81
`define BBT_IR_CAPT 8'h01
`define BBT_OP_EXTEST 8'h00
`define BBT_OP_SAMPLE 8'h82
`define BBT_OP_RUNT 8'h87
`define BBT_OP_BYPASS 8'hFF
// ==================================================
// boundary control register and its operations
`define BBT_BCR_RESET 3'h2
`define BBT_BCR_SIG 3'h2
`define BBT_BCR_PSEUDO_RANDOM_PATTERN_GENERATION 3'h3
`define BBT_BCR_SIGCNT 3'h4
// ==================================================
// identification, value is arbitrary
`define BBT_IDCODE 32'h0000_1001
`endif

// *** hdl/bbt_pkg.sv ***
/*
 * types for the bidirectional bus transceiver.
 * assumes nothing beyond a systemverilog compiler.
 */
package bbt_pkg;
  // ==================================================
  // test access port controller states
  typedef enum logic [3:0] {
    BBT_TLR, BBT_RTI, BBT_SDR, BBT_CDR, BBT_SHD, BBT_E1D, BBT_PD, BBT_E2D, BBT_UDR,
    BBT_SIR, BBT_CIR, BBT_SHI, BBT_E1I, BBT_PI, BBT_E2I, BBT_UIR
  } bbt_tap_t;
  // ==================================================
  // data register selected by the instruction
  typedef enum logic [1:0] {BBT_SEL_BYP, BBT_SEL_ID, BBT_SEL_BS, BBT_SEL_BCR} bbt_sel_t;
endpackage

// *** hdl/bbt_top.sv ***
/*
 * bidirectional bus transceiver with boundary test logic, all in one clock.
 * assumes every pin input is synchronous to core_clk_i; pin clocks and the
 * test clock are sampled and edge-detected, so they must run well below it.
 */
// Notes on behaviour
// - twenty-bit paths a to b and b to a with separate controls.
// - a-to-b latch enable high passes a data straight to b.
// - latch enable low holds stored value if clock enable high or clock still.
// - latch enable and clock enable low capture a on a-to-b clock rise.
// - b outputs driven when output enable low, high impedance when high.
// - b to a behaves identically with its own four controls.
// - test mode suppresses normal path; boundary cells own every pin.
// - test port activity in normal mode leaves the data path alone.
// - test logic samples pin data and can self test the cells.
// - signature compression on a inputs, pseudo-random patterns on b outputs.
// - all test and scan work follows the test clock only.
// - exactly one boundary cell per pin.
// - combined signature plus binary count operation exists under the run instruction.
// - test inputs sampled on test clock rise, outputs change on fall.
// - controller starts in reset state where normal function runs.
`timescale 1ns/100ps
`include "bbt_defines.svh"
module bbt_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // a port pins
  input wire logic [`BBT_W-1:0] a_in_i,
  output logic [`BBT_W-1:0] a_out_o,
  output logic a_oe_o,
  // b port pins
  input wire logic [`BBT_W-1:0] b_in_i,
  output logic [`BBT_W-1:0] b_out_o,
  output logic b_oe_o,
  // a to b controls
  input wire logic a_to_b_output_enable_n_i,
  input wire logic a_to_b_latch_enable_i,
  input wire logic a_to_b_clock_enable_n_i,
  input wire logic a_to_b_clock_i,
  // b to a controls
  input wire logic b_to_a_output_enable_n_i,
  input wire logic b_to_a_latch_enable_i,
  input wire logic b_to_a_clock_enable_n_i,
  input wire logic b_to_a_clock_i,
  // test access port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // stream of words captured by a-to-b clock edges
  output logic [`BBT_W-1:0] cap_data_o,
  output logic cap_valid_o,
  input wire logic cap_ready_i,
  output logic cap_accept_o
);
  // ==================================================
  // reset release through two flops
  logic rst_s1_q, rst_n;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
  // ==================================================
  // edge detection of sampled pin clocks and test clock
  logic abck_q, back_q, tck_q;
  logic ab_rise, ba_rise, tck_rise, tck_fall;
  assign ab_rise = a_to_b_clock_i & ~abck_q;
  assign ba_rise = b_to_a_clock_i & ~back_q;
  assign tck_rise = tck_i & ~tck_q;
  assign tck_fall = ~tck_i & tck_q;
  // ==================================================
  // test access port state and registers
  bbt_pkg::bbt_tap_t tap_q, tap_d;
  bbt_pkg::bbt_sel_t sel;
  logic [`BBT_IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
  logic [`BBT_BS_W-1:0] bs_q, bs_d, upd_q, upd_d, pins;
  logic [31:0] dr_q, dr_d;
  logic [2:0] bcr_q, bcr_d;
  logic [5:0] dlen;
  logic test_q, test_d, tdo_q, tdo_d, tdoe_q, tdoe_d;
  // maximal-length 20-bit shift, used for signature and pattern
  function automatic logic [`BBT_W-1:0] lfsr(input logic [`BBT_W-1:0] x);
    lfsr = {x[`BBT_W-2:0], x[`BBT_W-1] ^ x[16]};
  endfunction
  // one cell per pin, controls included
  assign pins = {a_to_b_output_enable_n_i, b_to_a_output_enable_n_i, b_to_a_clock_i,
                 a_to_b_clock_i, b_to_a_clock_enable_n_i, a_to_b_clock_enable_n_i,
                 b_to_a_latch_enable_i, a_to_b_latch_enable_i, b_in_i, a_in_i};
  // data register chosen by the current instruction
  always_comb begin
    unique case (ir_q)
      `BBT_IR_RESET: sel = bbt_pkg::BBT_SEL_ID;
      `BBT_OP_EXTEST, `BBT_OP_SAMPLE: sel = bbt_pkg::BBT_SEL_BS;
      `BBT_OP_RUNT: sel = bbt_pkg::BBT_SEL_BCR;
      default: sel = bbt_pkg::BBT_SEL_BYP;
    endcase
    dlen = (sel == bbt_pkg::BBT_SEL_ID) ? 6'd32 : (sel == bbt_pkg::BBT_SEL_BCR) ? 6'd3 : 6'd1;
  end
  // controller walk and register actions, all gated by test clock edges
  always_comb begin
    tap_d = tap_q;
    ir_d = ir_q;
    irs_d = irs_q;
    bs_d = bs_q;
    upd_d = upd_q;
    dr_d = dr_q;
    bcr_d = bcr_q;
    tdo_d = tdo_q;
    tdoe_d = tdoe_q;
    if (tck_rise) begin
      unique case (tap_q)
        bbt_pkg::BBT_TLR: tap_d = tms_i ? bbt_pkg::BBT_TLR : bbt_pkg::BBT_RTI;
        bbt_pkg::BBT_RTI: tap_d = tms_i ? bbt_pkg::BBT_SDR : bbt_pkg::BBT_RTI;
        bbt_pkg::BBT_SDR: tap_d = tms_i ? bbt_pkg::BBT_SIR : bbt_pkg::BBT_CDR;
        bbt_pkg::BBT_CDR, bbt_pkg::BBT_SHD: tap_d = tms_i ? bbt_pkg::BBT_E1D : bbt_pkg::BBT_SHD;
        bbt_pkg::BBT_E1D: tap_d = tms_i ? bbt_pkg::BBT_UDR : bbt_pkg::BBT_PD;
        bbt_pkg::BBT_PD: tap_d = tms_i ? bbt_pkg::BBT_E2D : bbt_pkg::BBT_PD;
        bbt_pkg::BBT_E2D: tap_d = tms_i ? bbt_pkg::BBT_UDR : bbt_pkg::BBT_SHD;
        bbt_pkg::BBT_UDR, bbt_pkg::BBT_UIR: tap_d = tms_i ? bbt_pkg::BBT_SDR : bbt_pkg::BBT_RTI;
        bbt_pkg::BBT_SIR: tap_d = tms_i ? bbt_pkg::BBT_TLR : bbt_pkg::BBT_CIR;
        bbt_pkg::BBT_CIR, bbt_pkg::BBT_SHI: tap_d = tms_i ? bbt_pkg::BBT_E1I : bbt_pkg::BBT_SHI;
        bbt_pkg::BBT_E1I: tap_d = tms_i ? bbt_pkg::BBT_UIR : bbt_pkg::BBT_PI;
        bbt_pkg::BBT_PI: tap_d = tms_i ? bbt_pkg::BBT_E2I : bbt_pkg::BBT_PI;
        bbt_pkg::BBT_E2I: tap_d = tms_i ? bbt_pkg::BBT_UIR : bbt_pkg::BBT_SHI;
      endcase
      unique case (tap_q)
        bbt_pkg::BBT_TLR: begin
          ir_d = `BBT_IR_RESET;
          bcr_d = `BBT_BCR_RESET;
          upd_d[`BBT_BS_OE_B:`BBT_BS_OE_A] = 2'b11;
        end
        bbt_pkg::BBT_RTI: begin
          // built-in operations run only under their own instruction
          if (ir_q == `BBT_OP_RUNT) begin
            if (bcr_q == `BBT_BCR_SIG || bcr_q == `BBT_BCR_SIGCNT)
              bs_d[`BBT_W-1:0] = lfsr(bs_q[`BBT_W-1:0]) ^ a_in_i;
            if (bcr_q == `BBT_BCR_PSEUDO_RANDOM_PATTERN_GENERATION)
              upd_d[`BBT_BS_CTL-1:`BBT_BS_B_LO] = lfsr(upd_q[`BBT_BS_CTL-1:`BBT_BS_B_LO]);
            if (bcr_q == `BBT_BCR_SIGCNT)
              upd_d[`BBT_BS_CTL-1:`BBT_BS_B_LO] = upd_q[`BBT_BS_CTL-1:`BBT_BS_B_LO] + 20'h0_0001;
          end
        end
        bbt_pkg::BBT_CDR: begin
          // sample snapshot, and in test mode the self test of the cells
          if (sel == bbt_pkg::BBT_SEL_BS) bs_d = pins;
          dr_d = (sel == bbt_pkg::BBT_SEL_ID) ? `BBT_IDCODE : 32'h0000_0000; // bypass loads 0
          if (sel == bbt_pkg::BBT_SEL_BCR) dr_d = {29'h0, bcr_q};
        end
        bbt_pkg::BBT_SHD: begin
          if (sel == bbt_pkg::BBT_SEL_BS) begin
            bs_d = {tdi_i, bs_q[`BBT_BS_W-1:1]};
          end else begin
            for (int i = 0; i < 32; i++) begin
              dr_d[i] = (i == int'(dlen) - 1) ? tdi_i : (i < int'(dlen) - 1) ? dr_q[i+1] : 1'b0;
            end
          end
        end
        bbt_pkg::BBT_UDR: begin
          if (sel == bbt_pkg::BBT_SEL_BS) upd_d = bs_q;
          if (sel == bbt_pkg::BBT_SEL_BCR) bcr_d = dr_q[2:0];
        end
        bbt_pkg::BBT_CIR: irs_d = `BBT_IR_CAPT;
        bbt_pkg::BBT_SHI: irs_d = {tdi_i, irs_q[`BBT_IR_W-1:1]};
        bbt_pkg::BBT_UIR: ir_d = irs_q;
        default: ;
      endcase
    end
    // serial output moves only on the falling test clock edge
    if (tck_fall) begin
      tdoe_d = (tap_q == bbt_pkg::BBT_SHD) || (tap_q == bbt_pkg::BBT_SHI);
      tdo_d = (tap_q == bbt_pkg::BBT_SHI) ? irs_q[0] :
              (sel == bbt_pkg::BBT_SEL_BS) ? bs_q[0] : dr_q[0];
    end
    // test mode only under instructions that drive pins
    test_d = (ir_d == `BBT_OP_EXTEST) || (ir_d == `BBT_OP_RUNT);
  end
  // register the test state
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= bbt_pkg::BBT_TLR;
      ir_q <= `BBT_IR_RESET;
      irs_q <= `BBT_IR_RESET;
      bs_q <= `BBT_BS_RESET;
      upd_q <= `BBT_BS_RESET;
      dr_q <= 32'h0000_0000;
      bcr_q <= `BBT_BCR_RESET;
      test_q <= 1'b0;
      tdo_q <= 1'b0;
      tdoe_q <= 1'b0;
      tck_q <= 1'b0;
    end else begin
      tap_q <= tap_d;
      ir_q <= ir_d;
      irs_q <= irs_d;
      bs_q <= bs_d;
      upd_q <= upd_d;
      dr_q <= dr_d;
      bcr_q <= bcr_d;
      test_q <= test_d;
      tdo_q <= tdo_d;
      tdoe_q <= tdoe_d;
      tck_q <= tck_i;
    end
  end
  // ==================================================
  // transceiver storage: one bit per bit, shared by latch and register
  logic [`BBT_W-1:0] ab_q, ab_d, ba_q, ba_d, aout_d, bout_d;
  logic ab_cap, ba_cap, aoe_d, boe_d;
  assign ab_cap = ~a_to_b_clock_enable_n_i & ab_rise;
  assign ba_cap = ~b_to_a_clock_enable_n_i & ba_rise;
  // storage freezes in test mode so normal state survives a test session
  always_comb begin
    ab_d = ab_q;
    ba_d = ba_q;
    if (!test_q) begin
      if (a_to_b_latch_enable_i || ab_cap) ab_d = a_in_i;
      if (b_to_a_latch_enable_i || ba_cap) ba_d = b_in_i;
    end
    // outputs follow next storage so transparency costs one cycle only
    bout_d = test_q ? upd_q[`BBT_BS_CTL-1:`BBT_BS_B_LO] : ab_d;
    aout_d = test_q ? upd_q[`BBT_W-1:0] : ba_d;
    boe_d = test_q ? ~upd_q[`BBT_BS_OE_B] : ~a_to_b_output_enable_n_i;
    aoe_d = test_q ? ~upd_q[`BBT_BS_OE_A] : ~b_to_a_output_enable_n_i;
  end
  // no data reset exists on the pins; reset only gives outputs a defined start
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ab_q <= 20'h0_0000;
      ba_q <= 20'h0_0000;
      b_out_o <= 20'h0_0000;
      a_out_o <= 20'h0_0000;
      b_oe_o <= 1'b0;
      a_oe_o <= 1'b0;
      abck_q <= 1'b0;
      back_q <= 1'b0;
    end else begin
      ab_q <= ab_d;
      ba_q <= ba_d;
      b_out_o <= bout_d;
      a_out_o <= aout_d;
      b_oe_o <= boe_d;
      a_oe_o <= aoe_d;
      abck_q <= a_to_b_clock_i;
      back_q <= b_to_a_clock_i;
    end
  end
  // ==================================================
  // two-entry buffer of clocked captures; a full buffer refuses new words
  logic [`BBT_W-1:0] hd_q, hd_d, tl_q, tl_d;
  logic vld_q, vld_d, hold_q, hold_d, push, pop;
  assign push = ab_cap & ~test_q & ~a_to_b_latch_enable_i & ~hold_q;
  assign pop = vld_q & cap_ready_i;
  always_comb begin
    hd_d = hd_q;
    tl_d = tl_q;
    vld_d = vld_q;
    hold_d = hold_q;
    if (pop) begin
      if (hold_q) begin
        hd_d = tl_q;
        hold_d = 1'b0;
      end else begin
        vld_d = 1'b0;
      end
    end
    if (push) begin
      if (vld_d) begin
        tl_d = a_in_i;
        hold_d = 1'b1;
      end else begin
        hd_d = a_in_i;
        vld_d = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hd_q <= 20'h0_0000;
      tl_q <= 20'h0_0000;
      vld_q <= 1'b0;
      hold_q <= 1'b0;
      cap_accept_o <= 1'b1;
    end else begin
      hd_q <= hd_d;
      tl_q <= tl_d;
      vld_q <= vld_d;
      hold_q <= hold_d;
      cap_accept_o <= ~hold_d;
    end
  end
  assign cap_data_o = hd_q;
  assign cap_valid_o = vld_q;
  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdoe_q;

  // ==================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);
  sequence s_ab_edge;
    !test_q && !a_to_b_latch_enable_i && !a_to_b_clock_enable_n_i && ab_rise;
  endsequence
  sequence s_ab_idle;
    !test_q && !a_to_b_latch_enable_i && (a_to_b_clock_enable_n_i || !ab_rise);
  endsequence
  a_ab_transparent: assert property (!test_q && a_to_b_latch_enable_i |=>
    b_out_o == $past(a_in_i)) else $error("b port not transparent");
  a_ab_hold_value: assert property (s_ab_idle |=> $stable(ab_q))
    else $error("a to b storage changed while held");
  a_ab_edge_capture: assert property (s_ab_edge |=> ab_q == $past(a_in_i))
    else $error("a to b clock edge not captured");
  a_b_hiz_enable: assert property (!test_q |=> b_oe_o == !$past(a_to_b_output_enable_n_i))
    else $error("b output enable wrong");
  a_ba_transparent: assert property (!test_q && b_to_a_latch_enable_i |=>
    a_out_o == $past(b_in_i) && a_oe_o == !$past(b_to_a_output_enable_n_i))
    else $error("a port not transparent");
  a_test_pin_drive: assert property (test_q |=>
    b_out_o == $past(upd_q[39:20]) && b_oe_o == !$past(upd_q[47]))
    else $error("boundary cells not driving b port");
  a_reset_normal: assert property (tap_q == bbt_pkg::BBT_TLR && tck_rise |-> ##2 !test_q)
    else $error("test mode left on in reset state");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> $past(tck_fall))
    else $error("serial output moved off falling edge");
  a_test_sync_tck: assert property ($changed(ir_q) || $changed(bcr_q) |-> $past(tck_rise))
    else $error("test register moved without test clock");
  a_normal_untouched: assert property (!test_q && $stable(test_q) && tck_rise &&
    !a_to_b_latch_enable_i && (a_to_b_clock_enable_n_i || !ab_rise) |=> $stable(b_out_o))
    else $error("data path disturbed");
  a_buf_no_loss: assert property (hold_q && !pop |=> hold_q && $stable(tl_q))
    else $error("buffered word lost");
endmodule

// *** verif/bbt_bus_model.sv ***
/*
 * board logic on both buses of the transceiver: drives each bus from a value
 * the bench chooses and gives way whenever the device drives that bus.
 * assumes the device enables are high while its pins are driven.
 */
`timescale 1ns/100ps
`include "bbt_defines.svh"
module bbt_bus_model (
  // values the board logic would drive
  input wire logic [`BBT_W-1:0] a_drv_i,
  input wire logic [`BBT_W-1:0] b_drv_i,
  // device pin outputs and enables
  input wire logic [`BBT_W-1:0] a_out_i,
  input wire logic a_oe_i,
  input wire logic [`BBT_W-1:0] b_out_i,
  input wire logic b_oe_i,
  // resolved bus levels seen by every party
  output logic [`BBT_W-1:0] a_bus_o,
  output logic [`BBT_W-1:0] b_bus_o
);
  // ==================================================
  // wire resolution: board backs off so the two never fight on a bus
  assign a_bus_o = a_oe_i ? a_out_i : a_drv_i;
  assign b_bus_o = b_oe_i ? b_out_i : b_drv_i;
endmodule

// *** verif/bbt_top_tb.sv ***
/*
 * self-checking bench: both data paths, capture buffer, test port.
 * assumes bbt_defines.svh on the include path and the bus model beside it.
 */
`timescale 1ns/100ps
`include "bbt_defines.svh"
module bbt_top_tb;
  localparam int W = `BBT_W;
  logic clk = 0;
  logic rst_b = 0;
  logic [W-1:0] a_drv = '0, b_drv = '0, a_bus, b_bus, a_out, b_out, cap_data;
  logic a_oe, b_oe, tdo, tdo_oe, oe_shift, cap_valid, cap_accept;
  logic oe_ab_n = 1, le_ab = 0, ce_ab_n = 1, ck_ab = 0;
  logic oe_ba_n = 1, le_ba = 0, ce_ba_n = 1, ck_ba = 0;
  logic tck = 0, tms = 1, tdi = 1, cap_ready = 0;
  int err_total = 0;
  int checks_done = 0;
  // ==================================================
  // device and board
  bbt_top i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .a_in_i(a_bus), .a_out_o(a_out),
    .a_oe_o(a_oe), .b_in_i(b_bus), .b_out_o(b_out), .b_oe_o(b_oe),
    .a_to_b_output_enable_n_i(oe_ab_n), .a_to_b_latch_enable_i(le_ab),
    .a_to_b_clock_enable_n_i(ce_ab_n), .a_to_b_clock_i(ck_ab),
    .b_to_a_output_enable_n_i(oe_ba_n), .b_to_a_latch_enable_i(le_ba),
    .b_to_a_clock_enable_n_i(ce_ba_n), .b_to_a_clock_i(ck_ba),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .cap_data_o(cap_data), .cap_valid_o(cap_valid), .cap_ready_i(cap_ready),
    .cap_accept_o(cap_accept));
  bbt_bus_model i_bus (.a_drv_i(a_drv), .b_drv_i(b_drv), .a_out_i(a_out), .a_oe_i(a_oe),
    .b_out_i(b_out), .b_oe_i(b_oe), .a_bus_o(a_bus), .b_bus_o(b_bus));
  initial begin
    forever #5 clk = ~clk;
  end
  // ==================================================
  // helpers: inputs always move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // pin clock high then low, three core cycles each so the edge detector sees it
  task automatic pulse(input bit ba);
    ck_ab = !ba;
    ck_ba = ba;
    step(3);
    ck_ab = 0;
    ck_ba = 0;
    step(3);
  endtask
  // one test clock: tms and tdi set while low, tdo read just before the rise
  task automatic tbit(input logic ms, input logic di, output logic so);
    tms = ms;
    tdi = di;
    step(3);
    so = tdo;
    tck = 1;
    step(3);
    tck = 0;
  endtask
  task automatic tap_reset();
    logic s;
    repeat (5) tbit(1, 1, s);
    tbit(0, 1, s);
  endtask
  // idle to idle through one scan, lsb first
  task automatic scan(input bit ir, input int n, input logic [47:0] din,
                      output logic [47:0] dout);
    logic s;
    dout = '0;
    tbit(1, 1, s);
    if (ir)
      tbit(1, 1, s);
    tbit(0, 1, s);
    tbit(0, 1, s);
    oe_shift = 1'b1;
    for (int i = 0; i < n; i++) begin
      tbit(i == n - 1, din[i], dout[i]);
      oe_shift = oe_shift & tdo_oe;
    end
    tbit(1, 1, s);
    tbit(0, 1, s);
  endtask
  // ==================================================
  // scenarios
  task automatic t_ident();
    logic [47:0] d;
    tap_reset();
    scan(0, 32, '0, d);
    chk(d[31:0], `BBT_IDCODE, "ident after reset");
    chk({oe_shift, tdo_oe}, 2'b10, "serial out enable");
  endtask
  task automatic t_ab();
    oe_ab_n = 0;
    le_ab = 1;
    a_drv = 20'h5A5A_5;
    step(3);
    chk(b_out, 20'h5A5A_5, "transparent");
    chk(b_oe, 1'b1, "b driven");
    le_ab = 0;
    a_drv = 20'h1234_5;
    pulse(0);
    chk(b_out, 20'h5A5A_5, "held by clock enable");
    ce_ab_n = 0;
    step(3);
    chk(b_out, 20'h5A5A_5, "held by static clock");
    pulse(0);
    chk(b_out, 20'h1234_5, "clocked capture");
    oe_ab_n = 1;
    step(3);
    chk(b_oe, 1'b0, "b released");
    oe_ab_n = 0;
  endtask
  // receiver stalls while three words arrive; the third finds the buffer full
  task automatic t_buf();
    step(1);
    chk(cap_valid, 1'b1, "word queued");
    chk(cap_data, 20'h1234_5, "head word");
    a_drv = 20'h0000_F;
    pulse(0);
    chk(cap_accept, 1'b0, "full at two");
    a_drv = 20'hFFFF_0;
    pulse(0);
    chk(b_out, 20'hFFFF_0, "path captures while full");
    cap_ready = 1;
    step(1);
    cap_ready = 0;
    step(1);
    chk(cap_data, 20'h0000_F, "second word in order");
    chk(cap_accept, 1'b1, "room again");
    cap_ready = 1;
    step(1);
    cap_ready = 0;
    step(2);
    chk(cap_valid, 1'b0, "refused word absent");
    ce_ab_n = 1;
  endtask
  task automatic t_ba();
    oe_ab_n = 1;
    oe_ba_n = 0;
    b_drv = 20'h3C3C_3;
    le_ba = 1;
    step(3);
    chk(a_out, 20'h3C3C_3, "b to a transparent");
    chk(a_oe, 1'b1, "a driven");
    le_ba = 0;
    ce_ba_n = 0;
    b_drv = 20'hC3C3_C;
    step(3);
    chk(a_out, 20'h3C3C_3, "b to a held");
    pulse(1);
    chk(a_out, 20'hC3C3_C, "b to a clocked");
    ce_ba_n = 1;
    oe_ba_n = 1;
  endtask
  task automatic t_test();
    logic [47:0] d;
    oe_ab_n = 0;
    le_ab = 1;
    a_drv = 20'h0F0F_0;
    scan(1, 8, `BBT_OP_SAMPLE, d);
    chk(d[7:0], `BBT_IR_CAPT, "ir capture");
    a_drv = 20'h9696_9;
    step(3);
    chk(b_out, 20'h9696_9, "path live beside test port");
    scan(0, 48, {2'b01, 6'h00, 20'hAAAA_A, 20'h0000_0}, d);
    chk(d[19:0], 20'h9696_9, "a pins sampled");
    chk(d[39:20], 20'h9696_9, "b pins sampled");
    scan(1, 8, `BBT_OP_EXTEST, d);
    step(3);
    chk(b_out, 20'hAAAA_A, "b pins from cells");
    chk({a_oe, b_oe}, 2'b01, "enables from cells");
    tap_reset();
    step(3);
    chk(b_out, 20'h9696_9, "normal after test reset");
  endtask
  // built-in run: binary count, then one pattern step on the b cells, then bypass
  task automatic t_run();
    logic [47:0] d;
    scan(1, 8, `BBT_OP_RUNT, d);
    scan(0, 3, `BBT_BCR_SIGCNT, d);
    chk(d[2:0], `BBT_BCR_RESET, "control reset value");
    chk({b_oe, b_out}, {1'b0, 20'hAAAA_A}, "cells own b pins");
    tbit(0, 1, d[0]);
    tbit(0, 1, d[0]);
    chk(b_out, 20'hAAAA_C, "binary count");
    scan(0, 3, `BBT_BCR_PSEUDO_RANDOM_PATTERN_GENERATION, d);
    chk(d[2:0], `BBT_BCR_SIGCNT, "control read back");
    tbit(0, 1, d[0]);
    chk(b_out, 20'h5555_B, "pattern step");
    scan(1, 8, `BBT_OP_BYPASS, d);
    scan(0, 1, 48'h0000_0000_0001, d);
    chk(d[0], 1'b0, "bypass captures zero");
    tap_reset();
  endtask
  // ==================================================
  // main sequence and hang guard
  initial begin
    step(5);
    chk({a_oe, b_oe, cap_valid, cap_accept}, 4'b0001, "outputs in reset");
    rst_b = 1;
    step(4);
    t_ident();
    t_ab();
    t_buf();
    t_ba();
    t_test();
    t_run();
    tally_and_finish();
  end
  initial begin
    #900000;
    err_total++;
    tally_and_finish();
  end
endmodule
